// ===== core/atia_pkg.sv
// Constants, types and helper functions shared by the indirect access block.
package atia_pkg;

  localparam logic [7:0] ATIA_ADDR_SELECT = 8'h6E;
  localparam logic [7:0] ATIA_ADDR_OFFSET = 8'h6F;
  localparam logic [7:0] ATIA_ADDR_DATA = 8'hA0;

  localparam int ATIA_SEL_CLASS_HI = 7;
  localparam int ATIA_SEL_CLASS_LO = 5;
  localparam int ATIA_SEL_DIR_BIT = 4;
  localparam int ATIA_SEL_PORT_HI = 3;
  localparam logic [2:0] ATIA_CLASS_ACL = 3'h2;
  localparam logic [3:0] ATIA_PORT_FIRST = 4'h1;
  localparam logic [3:0] ATIA_PORT_LAST = 4'h5;

  localparam logic [7:0] ATIA_OFS_BUF_LAST = 8'h0D;
  localparam logic [7:0] ATIA_OFS_MASK_HI = 8'h10;
  localparam logic [7:0] ATIA_OFS_MASK_LO = 8'h11;
  localparam logic [7:0] ATIA_OFS_ACCESS_CTRL = 8'h12;
  localparam logic [7:0] ATIA_OFS_FILTER_CTRL = 8'h13;

  localparam int ATIA_CTRL_WSTAT_BIT = 6;
  localparam int ATIA_CTRL_RSTAT_BIT = 5;
  localparam int ATIA_CTRL_REQ_WR_BIT = 4;
  localparam int ATIA_CTRL_ENTRY_HI = 3;
  localparam int ATIA_MASK_HI_BITS = 6;

  localparam int ATIA_NUM_PORTS = 5;
  localparam int ATIA_NUM_ENTRIES = 16;
  localparam int ATIA_ENTRY_BYTES = 14;
  localparam int ATIA_PORT_W = 3;
  localparam int ATIA_ENTRY_W = 4;
  localparam int ATIA_IDX_W = 4;
  localparam int ATIA_MEM_AW = 11;
  localparam int ATIA_MEM_WORDS = ATIA_NUM_PORTS * ATIA_NUM_ENTRIES * ATIA_ENTRY_BYTES;
  localparam logic [ATIA_IDX_W-1:0] ATIA_LAST_BYTE = 4'hD;

  localparam logic [ATIA_ENTRY_BYTES-1:0] ATIA_MASK_RST = 14'h0000;
  localparam logic ATIA_STAT_RST = 1'b1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atia_host_req_t;

  typedef struct packed {
    logic wr;
    logic [ATIA_PORT_W-1:0] port;
    logic [ATIA_ENTRY_W-1:0] entry;
    logic [ATIA_ENTRY_BYTES-1:0] mask;
    logic [ATIA_ENTRY_BYTES*8-1:0] data;
  } atia_xfer_t;

  typedef enum logic {ATIA_MV_IDLE, ATIA_MV_MOVE} atia_mv_state_t;

  // Mask bit 0 selects the last entry byte, the top bit selects byte 0.
  function automatic logic byte_enabled(input logic [ATIA_ENTRY_BYTES-1:0] mask,
                                        input logic [ATIA_IDX_W-1:0] idx);
    byte_enabled = mask[ATIA_LAST_BYTE - idx];
  endfunction

  function automatic logic [7:0] pick_byte(input logic [ATIA_ENTRY_BYTES*8-1:0] data,
                                           input logic [ATIA_IDX_W-1:0] idx);
    pick_byte = data[{idx, 3'h0} +: 8];
  endfunction

  function automatic logic [ATIA_MEM_AW-1:0] table_addr(input logic [ATIA_PORT_W-1:0] port,
                                                        input logic [ATIA_ENTRY_W-1:0] entry,
                                                        input logic [ATIA_IDX_W-1:0] idx);
    table_addr = ATIA_MEM_AW'((port * ATIA_NUM_ENTRIES + entry) * ATIA_ENTRY_BYTES + idx);
  endfunction

endpackage

// ===== core/atia_entry_mover.sv
// Table memory and the byte stepper that moves one entry to or from a holding buffer.
module atia_entry_mover
  import atia_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input atia_xfer_t xfer,
  output logic busy,
  output logic byte_fetch,
  output logic [ATIA_IDX_W-1:0] byte_idx,
  output logic [7:0] byte_data,
  output logic done
);

  logic [7:0] table_mem [ATIA_MEM_WORDS];
  atia_mv_state_t state_ff;
  atia_xfer_t job_ff;
  logic [ATIA_IDX_W-1:0] idx_ff;

  wire last_byte = (idx_ff == ATIA_LAST_BYTE);
  wire byte_sel = byte_enabled(job_ff.mask, idx_ff);
  wire [ATIA_MEM_AW-1:0] mem_addr = table_addr(job_ff.port, job_ff.entry, idx_ff);

  assign busy = (state_ff == ATIA_MV_MOVE);
  assign byte_fetch = busy && !job_ff.wr && byte_sel;
  assign byte_idx = idx_ff;
  assign byte_data = table_mem[mem_addr];
  assign done = busy && last_byte;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ATIA_MV_IDLE;
      job_ff <= '0;
      idx_ff <= '0;
    end else begin
      unique case (state_ff)
        ATIA_MV_IDLE: begin
          if (start) begin
            job_ff <= xfer;
            idx_ff <= '0;
            state_ff <= ATIA_MV_MOVE;
          end
        end
        ATIA_MV_MOVE: begin
          idx_ff <= idx_ff + 4'h1;
          if (last_byte) begin
            state_ff <= ATIA_MV_IDLE;
          end
        end
      endcase
    end
  end

  // Only enabled bytes of the entry are overwritten on a table write.
  always_ff @(posedge core_clk) begin
    if (busy && job_ff.wr && byte_sel) begin
      table_mem[mem_addr] <= pick_byte(job_ff.data, idx_ff);
    end
  end

endmodule

// ===== core/atia_acl_access.sv
// Per-port indirect access logic for the access-control-list table.
module atia_acl_access
  import atia_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input atia_host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic [ATIA_NUM_PORTS-1:0] redundancy_single_entry_miss
);

  logic [7:0] sel_ff;
  logic [7:0] ofs_ff;
  logic [7:0] host_rdata_ff;
  logic [ATIA_NUM_PORTS-1:0][ATIA_ENTRY_BYTES*8-1:0] hold_ff;
  logic [ATIA_NUM_PORTS-1:0][ATIA_ENTRY_BYTES-1:0] entry_byte_select_mask_ff;
  logic [ATIA_NUM_PORTS-1:0][ATIA_ENTRY_W-1:0] entry_ff;
  logic [ATIA_NUM_PORTS-1:0] req_wr_ff;
  logic [ATIA_NUM_PORTS-1:0] wr_done_ff;
  logic [ATIA_NUM_PORTS-1:0] rd_done_ff;
  logic [ATIA_NUM_PORTS-1:0] miss_ff;
  logic [ATIA_PORT_W-1:0] act_port_ff;
  logic act_wr_ff;

  logic mv_busy;
  logic mv_fetch;
  logic [ATIA_IDX_W-1:0] mv_idx;
  logic [7:0] mv_data;
  logic mv_done;
  atia_xfer_t xfer;

  // Select decode.
  wire [3:0] sel_port = sel_ff[ATIA_SEL_PORT_HI:0];
  wire sel_acl = (sel_ff[ATIA_SEL_CLASS_HI:ATIA_SEL_CLASS_LO] == ATIA_CLASS_ACL);
  wire port_ok = sel_acl && (sel_port >= ATIA_PORT_FIRST) && (sel_port <= ATIA_PORT_LAST);
  wire [ATIA_PORT_W-1:0] pidx = ATIA_PORT_W'(sel_port - ATIA_PORT_FIRST);
  wire sel_read = sel_ff[ATIA_SEL_DIR_BIT];

  // Host strobes.
  wire sel_wr = host_req.wr && (host_req.addr == ATIA_ADDR_SELECT);
  wire ofs_wr = host_req.wr && (host_req.addr == ATIA_ADDR_OFFSET);
  wire data_wr = host_req.wr && (host_req.addr == ATIA_ADDR_DATA) && port_ok && !sel_read;
  wire data_rd = host_req.rd && (host_req.addr == ATIA_ADDR_DATA) && port_ok && sel_read;
  wire in_buf = (ofs_ff <= ATIA_OFS_BUF_LAST);
  wire ctrl_wr = data_wr && (ofs_ff == ATIA_OFS_ACCESS_CTRL);
  wire start = ctrl_wr && !mv_busy;

  // Per-port register read-back.
  wire [ATIA_ENTRY_BYTES*8-1:0] cur_hold = hold_ff[pidx];
  wire [ATIA_ENTRY_BYTES-1:0] cur_mask = entry_byte_select_mask_ff[pidx];
  wire [7:0] ctrl_val = {1'b0, wr_done_ff[pidx], rd_done_ff[pidx], req_wr_ff[pidx],
                         entry_ff[pidx]};
  wire [7:0] filt_val = {7'h00, miss_ff[pidx]};
  wire [7:0] mask_hi_val = {2'h0, cur_mask[ATIA_ENTRY_BYTES-1:8]};
  wire [7:0] reg_val =
    in_buf ? pick_byte(cur_hold, ofs_ff[ATIA_IDX_W-1:0]) :
    (ofs_ff == ATIA_OFS_MASK_HI) ? mask_hi_val :
    (ofs_ff == ATIA_OFS_MASK_LO) ? cur_mask[7:0] :
    (ofs_ff == ATIA_OFS_ACCESS_CTRL) ? ctrl_val :
    (ofs_ff == ATIA_OFS_FILTER_CTRL) ? filt_val : 8'h00;
  wire [7:0] rd_val = (host_req.addr == ATIA_ADDR_SELECT) ? sel_ff :
                      (host_req.addr == ATIA_ADDR_OFFSET) ? ofs_ff :
                      data_rd ? reg_val : 8'h00;

  assign xfer.wr = host_req.wdata[ATIA_CTRL_REQ_WR_BIT];
  assign xfer.port = pidx;
  assign xfer.entry = host_req.wdata[ATIA_CTRL_ENTRY_HI:0];
  assign xfer.mask = cur_mask;
  assign xfer.data = cur_hold;

  assign host_rdata = host_rdata_ff;
  assign redundancy_single_entry_miss = miss_ff;

  atia_entry_mover u_mover (
    .core_clk(core_clk),
    .rst(rst),
    .start(start),
    .xfer(xfer),
    .busy(mv_busy),
    .byte_fetch(mv_fetch),
    .byte_idx(mv_idx),
    .byte_data(mv_data),
    .done(mv_done)
  );

  // Select, offset and read data. Buffer accesses step the offset for bursts.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_ff <= 8'h00;
      ofs_ff <= 8'h00;
      host_rdata_ff <= 8'h00;
    end else begin
      if (sel_wr) begin
        sel_ff <= host_req.wdata;
      end
      if (ofs_wr) begin
        ofs_ff <= host_req.wdata;
      end else if ((data_wr || data_rd) && (ofs_ff < ATIA_OFS_BUF_LAST)) begin
        ofs_ff <= ofs_ff + 8'h01;
      end
      if (host_req.rd) begin
        host_rdata_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_port_ff <= '0;
      act_wr_ff <= 1'b0;
    end else if (start) begin
      act_port_ff <= pidx;
      act_wr_ff <= xfer.wr;
    end
  end

  // Per-port holding buffer, mask, request fields and completion flags.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_ff <= '0;
      entry_byte_select_mask_ff <= '0;
      entry_ff <= '0;
      req_wr_ff <= '0;
      wr_done_ff <= {ATIA_NUM_PORTS{ATIA_STAT_RST}};
      rd_done_ff <= {ATIA_NUM_PORTS{ATIA_STAT_RST}};
      miss_ff <= '0;
    end else begin
      for (int p = 0; p < ATIA_NUM_PORTS; p++) begin
        if (data_wr && (pidx == ATIA_PORT_W'(p))) begin
          if (in_buf) begin
            hold_ff[p][{ofs_ff[ATIA_IDX_W-1:0], 3'h0} +: 8] <= host_req.wdata;
          end
          if (ofs_ff == ATIA_OFS_MASK_HI) begin
            entry_byte_select_mask_ff[p][ATIA_ENTRY_BYTES-1:8] <=
              host_req.wdata[ATIA_MASK_HI_BITS-1:0];
          end
          if (ofs_ff == ATIA_OFS_MASK_LO) begin
            entry_byte_select_mask_ff[p][7:0] <= host_req.wdata;
          end
          if (ofs_ff == ATIA_OFS_ACCESS_CTRL) begin
            req_wr_ff[p] <= host_req.wdata[ATIA_CTRL_REQ_WR_BIT];
            entry_ff[p] <= host_req.wdata[ATIA_CTRL_ENTRY_HI:0];
          end
          if (ofs_ff == ATIA_OFS_FILTER_CTRL) begin
            miss_ff[p] <= host_req.wdata[0];
          end
        end
        // Table bytes land after host writes so a read result is never lost.
        if (mv_fetch && (act_port_ff == ATIA_PORT_W'(p))) begin
          hold_ff[p][{mv_idx, 3'h0} +: 8] <= mv_data;
        end
        if (start && (pidx == ATIA_PORT_W'(p))) begin
          if (xfer.wr) begin
            wr_done_ff[p] <= 1'b0;
          end else begin
            rd_done_ff[p] <= 1'b0;
          end
        end
        // The running job's type picks the bit, as a control write while busy may change it.
        if (mv_done && (act_port_ff == ATIA_PORT_W'(p))) begin
          wr_done_ff[p] <= wr_done_ff[p] | act_wr_ff;
          rd_done_ff[p] <= rd_done_ff[p] | !act_wr_ff;
        end
      end
    end
  end

endmodule

// ===== test/atia_acl_access_chk.sv
// Port-level assertions for the indirect access-control-list access block.
module atia_acl_access_chk
  import atia_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input atia_host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic [ATIA_NUM_PORTS-1:0] redundancy_single_entry_miss
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] sel_ff;
  logic ofs13_ff;
  wire logic rd_data = host_req.rd && host_req.addr == ATIA_ADDR_DATA;
  wire logic acl_w = sel_ff[7:4] == 4'h4 && sel_ff[3:0] inside {[1:5]};
  wire logic mode_wr = host_req.wr && host_req.addr == ATIA_ADDR_DATA && ofs13_ff && acl_w;
  wire logic [2:0] pidx = 3'(sel_ff[3:0] - 4'h1);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_ff <= 8'h00;
      ofs13_ff <= 1'b0;
    end else begin
      if (host_req.wr && host_req.addr == ATIA_ADDR_SELECT) sel_ff <= host_req.wdata;
      if (host_req.wr && host_req.addr == ATIA_ADDR_OFFSET) begin
        ofs13_ff <= host_req.wdata == ATIA_OFS_FILTER_CTRL;
      end
    end
  end
  sequence s_mode_wr;
    mode_wr ##1 1'b1;
  endsequence
  property p_hold;
    !host_req.rd |=> $stable(host_rdata);
  endproperty
  property p_unmapped;
    host_req.rd && !(host_req.addr inside {8'h6E, 8'h6F, 8'hA0}) |=> host_rdata == 8'h00;
  endproperty
  property p_sel_back;
    host_req.rd && host_req.addr == ATIA_ADDR_SELECT |=> host_rdata == $past(sel_ff);
  endproperty
  property p_class;
    rd_data && sel_ff[7:5] != ATIA_CLASS_ACL |=> host_rdata == 8'h00;
  endproperty
  property p_dir;
    rd_data && !sel_ff[4] |=> host_rdata == 8'h00;
  endproperty
  property p_mode_set;
    s_mode_wr |-> redundancy_single_entry_miss[$past(pidx)] == $past(host_req.wdata[0]);
  endproperty
  property p_mode_cause;
    $changed(redundancy_single_entry_miss) |-> $past(mode_wr);
  endproperty
  property p_mode_one;
    $changed(redundancy_single_entry_miss) |->
      $onehot(redundancy_single_entry_miss ^ $past(redundancy_single_entry_miss));
  endproperty
  property p_reserved;
    rd_data && ofs13_ff |=> host_rdata[7:1] == 7'h00;
  endproperty
  property p_rst_out;
    $fell(rst) |-> host_rdata == 8'h00 && redundancy_single_entry_miss == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_sel_back: assert property (p_sel_back) else $error("select readback wrong");
  a_class: assert property (p_class) else $error("foreign class read not zero");
  a_dir: assert property (p_dir) else $error("write direction read not zero");
  a_mode_set: assert property (p_mode_set) else $error("filter mode not stored");
  a_mode_cause: assert property (p_mode_cause) else $error("filter mode moved");
  a_mode_one: assert property (p_mode_one) else $error("filter mode multi change");
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  a_rst_out: assert property (p_rst_out) else $error("outputs not zero at reset");
endmodule

// ===== test/atia_host_model.sv
// Host model that drives the indirect register bus of the access block.
module atia_host_model
  import atia_pkg::*;
(
  input wire logic core_clk,
  output atia_host_req_t host_req,
  input wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_req <= '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    host_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    host_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    host_req <= '{1'b0, 1'b0, ~a, 8'hFF};
    d = host_rdata;
  endtask
  task automatic sel(input logic rdir, input logic [3:0] p, input logic [7:0] ofs);
    wr(ATIA_ADDR_SELECT, {ATIA_CLASS_ACL, rdir, p});
    wr(ATIA_ADDR_OFFSET, ofs);
  endtask
  // Polls the control register until the given status bit is set, giving up after 40 reads.
  task automatic poll(input int b, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < 40 && v[b] !== 1'b1; i++) rd(ATIA_ADDR_DATA, v);
  endtask
endmodule

// ===== test/tb_atia_acl_access.sv
// Self-checking bench for the indirect access-control-list access block.
module tb_atia_acl_access;
  import atia_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  atia_host_req_t host_req;
  logic [7:0] host_rdata;
  logic [ATIA_NUM_PORTS-1:0] miss;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] v;
  always #25 core_clk = ~core_clk;
  atia_acl_access dut (.core_clk(core_clk), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .redundancy_single_entry_miss(miss));
  atia_host_model host (.core_clk(core_clk), .host_req(host_req), .host_rdata(host_rdata));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] pat(input int s, input int i);
    pat = 8'(s * 16 + i * 7);
  endfunction
  task automatic mask(input logic [3:0] p, input logic [13:0] m);
    host.sel(1'b0, p, ATIA_OFS_MASK_HI);
    host.wr(ATIA_ADDR_DATA, {2'h0, m[13:8]});
    host.sel(1'b0, p, ATIA_OFS_MASK_LO);
    host.wr(ATIA_ADDR_DATA, m[7:0]);
  endtask
  task automatic table_wr(input logic [3:0] p, input logic [3:0] e, input logic [13:0] m,
                          input int s);
    host.sel(1'b1, p, ATIA_OFS_ACCESS_CTRL);
    host.poll(6, v);
    host.sel(1'b0, p, 8'h00);
    for (int i = 0; i < 14; i++) host.wr(ATIA_ADDR_DATA, pat(s, i));
    mask(p, m);
    host.sel(1'b0, p, ATIA_OFS_ACCESS_CTRL);
    host.wr(ATIA_ADDR_DATA, {4'h1, e});
    host.sel(1'b1, p, ATIA_OFS_ACCESS_CTRL);
    host.rd(ATIA_ADDR_DATA, v);
    check("write busy", {4'h3, e}, v);
    host.poll(6, v);
    check("write done", {4'h7, e}, v);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    host.sel(1'b1, 4'h1, ATIA_OFS_ACCESS_CTRL);
    host.rd(ATIA_ADDR_DATA, v);
    check("ctrl reset", 8'h60, v);
    host.rd(ATIA_ADDR_SELECT, v);
    check("select", 8'h51, v);
    host.rd(8'h33, v);
    check("unmapped", 8'h00, v);
    table_wr(4'h5, 4'hF, 14'h3FFF, 1);
    table_wr(4'h5, 4'hF, 14'h1555, 2);
    // A read request stored while a write runs must not leave the write status low.
    host.sel(1'b0, 4'h5, ATIA_OFS_ACCESS_CTRL);
    host.wr(ATIA_ADDR_DATA, 8'h1F);
    host.wr(ATIA_ADDR_DATA, 8'h00);
    host.sel(1'b1, 4'h5, ATIA_OFS_ACCESS_CTRL);
    host.poll(6, v);
    check("busy ctrl kept", 8'h60, v);
    mask(4'h5, 14'h3FFF);
    host.sel(1'b0, 4'h5, 8'h00);
    for (int i = 0; i < 14; i++) host.wr(ATIA_ADDR_DATA, 8'h00);
    host.sel(1'b0, 4'h5, ATIA_OFS_ACCESS_CTRL);
    host.wr(ATIA_ADDR_DATA, 8'h0F);
    host.sel(1'b1, 4'h5, ATIA_OFS_ACCESS_CTRL);
    host.rd(ATIA_ADDR_DATA, v);
    check("read busy", 8'h4F, v);
    host.poll(5, v);
    check("read done", 8'h6F, v);
    host.sel(1'b1, 4'h5, 8'h00);
    for (int i = 0; i < 14; i++) begin
      host.rd(ATIA_ADDR_DATA, v);
      check("entry byte", pat((i % 2 == 1) ? 2 : 1, i), v);
    end
    host.wr(ATIA_ADDR_SELECT, 8'h23);
    host.wr(ATIA_ADDR_OFFSET, ATIA_OFS_FILTER_CTRL);
    host.wr(ATIA_ADDR_DATA, 8'hFF);
    host.rd(ATIA_ADDR_DATA, v);
    check("class", 8'h00, {3'h0, miss} | v);
    host.sel(1'b1, 4'h2, ATIA_OFS_FILTER_CTRL);
    host.wr(ATIA_ADDR_DATA, 8'hFF);
    check("read dir", 8'h00, {3'h0, miss});
    for (int p = 1; p <= 5; p++) begin
      host.sel(1'b0, 4'(p), ATIA_OFS_FILTER_CTRL);
      host.wr(ATIA_ADDR_DATA, 8'hFF);
      check("mode", 8'((1 << p) - 1), {3'h0, miss});
      host.rd(ATIA_ADDR_DATA, v);
      check("write dir read", 8'h00, v);
      host.sel(1'b1, 4'(p), ATIA_OFS_FILTER_CTRL);
      host.rd(ATIA_ADDR_DATA, v);
      check("mode read", 8'h01, v);
    end
    host.sel(1'b0, 4'h3, ATIA_OFS_FILTER_CTRL);
    host.wr(ATIA_ADDR_DATA, 8'h00);
    check("mode clear", 8'h1B, {3'h0, miss});
    end_sim();
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule
bind atia_acl_access atia_acl_access_chk chk (.core_clk(core_clk), .rst(rst),
  .host_req(host_req), .host_rdata(host_rdata),
  .redundancy_single_entry_miss(redundancy_single_entry_miss));
